/* hdl/stb_timer.sv */
// 16-bit timer/counter with register port, prescaler and chained event input
// Notes on behaviour
// - event mode direction bit: 0 down, 1 up
// - no reload: wrap to ffff or 0000
// - reload bit: load reload value on wrap
// - reload bit ignored in one-shot mode
// - power down stops timer and gates clocks
// - sleep holds counter at reload, enable kept
// - after sleep, enabled timer restarts from reload
// - status bit mirrors sleep request input
// - clock request low when sleeping, powered down, or disabled with no one-shot running
// - clock select halves rate, codes 1xxx reserved
// - event edge select, code 11 counts nothing
// - one-shot trigger edge or enable bit
// - event source is previous timer overflow
// - reload value is the start value; counting limits are ffff and 0000
// - running reload write waits for wrap
// - count register reads live counter
// - mode field timer, event, one-shot, reserved
// - enable starts/stops; self-clears in one-shot
// - reset bit reloads, clears enable, self-clears
// - interrupt request on every underflow
`timescale 1ns/1ps
`include "stb_cfg.svh"
module stb_timer
    import stb_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    // system
    input wire logic sleep_req_in,
    input wire logic event_src_in,
    output logic clock_request_out,
    output logic wrap_pulse_out,
    output logic irq_out
);
    if (ADDR_W < 4) begin : g_chk
        $error("stb_timer: ADDR_W must be at least 4");
    end

    stb_ctrl_t ctl, next_ctl;
    stb_clkev_t clkev, next_clkev;
    stb_state_t st, next_st;
    logic [15:0] reload_val, next_reload_val;
    logic [15:0] count, next_count;
    logic [6:0] presc, next_presc;
    logic ev_prev, next_ev_prev;
    logic [31:0] next_rdata;
    logic next_clkreq, next_pulse, next_irq;
    logic halted, tm_run, ev_run, os_run, running, up;
    logic tick, ev_hit, step, at_lim, wrap, under, os_start;
    logic wr_ctrl, wr_clkev, wr_reload;

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        case (sel)
            `STB_EDGE_FALL: edge_hit = prev & ~cur;
            `STB_EDGE_RISE: edge_hit = ~prev & cur;
            `STB_EDGE_BOTH: edge_hit = prev ^ cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [6:0] presc_mask(input logic [2:0] sel);
        logic [6:0] m;
        m = `STB_PRESC_ONES << sel;
        presc_mask = ~m;
    endfunction

    // decode and run conditions
    always_comb begin
        wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_W'(`STB_CTRL_OFS));
        wr_clkev = reg_wr_in && (reg_addr_in == ADDR_W'(`STB_CLKEV_OFS));
        wr_reload = reg_wr_in && (reg_addr_in == ADDR_W'(`STB_RELOAD_OFS));
        halted = ctl.reset | sleep_req_in | ctl.power_down;
        // only code 1xxx or power down gives no tick; base rate is this block's clock
        tick = !ctl.power_down && !clkev.clock_select[3] &&
               ((presc & presc_mask(clkev.clock_select[2:0])) ==
                presc_mask(clkev.clock_select[2:0]));
        ev_hit = edge_hit(clkev.edge_sel, ev_prev, event_src_in);
        tm_run = (ctl.mode == `STB_MODE_TIMER) && ctl.enable && !halted;
        ev_run = (ctl.mode == `STB_MODE_EVENT) && ctl.enable && !halted &&
                 !clkev.event_sel;
        os_run = (st == ST_SHOT) && (ctl.mode == `STB_MODE_ONESHOT) && !halted;
        running = tm_run | ev_run | os_run;
        up = ev_run && ctl.count_direction;
        step = (tm_run && tick) | (ev_run && ev_hit) | (os_run && tick);
        at_lim = up ? (count == `STB_CNT_MAX) : (count == `STB_CNT_MIN);
        wrap = step && at_lim;
        under = wrap && !up;
        os_start = (ctl.mode == `STB_MODE_ONESHOT) && (st == ST_IDLE) &&
                   ctl.enable && !halted &&
                   ((clkev.edge_sel == `STB_EDGE_ENABLE) ||
                    edge_hit(clkev.edge_sel, ev_prev, event_src_in));
    end

    // next values of the timer state
    always_comb begin
        next_presc = ctl.power_down ? presc : presc + 7'h1;
        next_ev_prev = event_src_in;
        next_reload_val = wr_reload ? reg_wdata_in[15:0] : reload_val;
        next_clkev = clkev;
        if (wr_clkev) begin
            next_clkev = stb_clkev_t'(reg_wdata_in[15:0] & `STB_CLKEV_WMASK);
        end
        next_ctl = ctl;
        if (wr_ctrl) begin
            next_ctl = stb_ctrl_t'(reg_wdata_in[15:0] & `STB_CTRL_WMASK);
        end
        if (ctl.reset) begin
            next_ctl.reset = 1'b0;
            next_ctl.enable = 1'b0;
        end
        if (os_start) begin
            next_ctl.enable = 1'b0;
        end
        next_st = st;
        if (ctl.reset || sleep_req_in || ctl.mode != `STB_MODE_ONESHOT) begin
            next_st = ST_IDLE;
        end else if (os_start) begin
            next_st = ST_SHOT;
        end else if (os_run && wrap) begin
            next_st = ST_IDLE;
        end
        // sleep keeps the counter at reload so wake resumes from it
        next_count = count;
        if (ctl.reset || sleep_req_in) begin
            next_count = reload_val;
        end else if (step) begin
            if (!at_lim) begin
                next_count = up ? count + 16'h1 : count - 16'h1;
            end else if (os_run) begin
                next_count = count;
            end else if (ctl.reload_on_wrap) begin
                next_count = reload_val;
            end else begin
                next_count = up ? `STB_CNT_MIN : `STB_CNT_MAX;
            end
        end else if (os_start) begin
            next_count = reload_val;
        end else if (wr_reload && !running) begin
            // a stopped timer takes a new reload value at once
            next_count = reg_wdata_in[15:0];
        end
        next_pulse = wrap;
        next_irq = under;
        next_clkreq = !sleep_req_in && !ctl.power_down &&
                      (ctl.enable || st == ST_SHOT);
    end

    // register read data, valid the cycle after a read strobe
    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_W'(`STB_CTRL_OFS): begin
                    next_rdata[15:0] = ctl;
                    next_rdata[`STB_CTRL_SLEEP_BIT] = sleep_req_in;
                    next_rdata[`STB_CTRL_CLKREQ_BIT] = clock_request_out;
                end
                ADDR_W'(`STB_CLKEV_OFS): next_rdata[15:0] = clkev;
                ADDR_W'(`STB_RELOAD_OFS): next_rdata[15:0] = reload_val;
                ADDR_W'(`STB_COUNT_OFS): next_rdata[15:0] = count;
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctl <= stb_ctrl_t'(`STB_CTRL_RST);
            clkev <= stb_clkev_t'(`STB_CLKEV_RST);
            st <= ST_IDLE;
            reload_val <= `STB_RELOAD_RST;
            count <= `STB_COUNT_RST;
            presc <= 7'h0;
            ev_prev <= 1'b0;
            reg_rdata_out <= 32'h0;
            clock_request_out <= 1'b0;
            wrap_pulse_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            ctl <= next_ctl;
            clkev <= next_clkev;
            st <= next_st;
            reload_val <= next_reload_val;
            count <= next_count;
            presc <= next_presc;
            ev_prev <= next_ev_prev;
            reg_rdata_out <= next_rdata;
            clock_request_out <= next_clkreq;
            wrap_pulse_out <= next_pulse;
            irq_out <= next_irq;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    count_down_a: assert property (
        ev_run && !up && ev_hit && !at_lim |=> count == $past(count) - 16'h1)
        else $error("event down count did not decrement");
    count_up_a: assert property (
        ev_run && up && ev_hit && !at_lim |=> count == $past(count) + 16'h1)
        else $error("event up count did not increment");
    roll_over_a: assert property (
        (tm_run || ev_run) && wrap && !ctl.reload_on_wrap |=>
        count == ($past(up) ? `STB_CNT_MIN : `STB_CNT_MAX))
        else $error("roll over value wrong");
    wrap_reload_a: assert property (
        (tm_run || ev_run) && wrap && ctl.reload_on_wrap |=>
        count == $past(reload_val))
        else $error("wrap did not load reload value");
    oneshot_stop_a: assert property (
        os_run && wrap |=> st == ST_IDLE && count == `STB_CNT_MIN ##1 st == ST_IDLE)
        else $error("one-shot did not stop on underflow");
    power_hold_a: assert property (
        ctl.power_down && !ctl.reset && !sleep_req_in && !wr_reload |=> $stable(count))
        else $error("counter moved while powered down");
    sleep_load_a: assert property (
        sleep_req_in && !ctl.reset && !reg_wr_in |=>
        count == $past(reload_val) && ctl.enable == $past(ctl.enable))
        else $error("sleep did not hold counter at reload");
    sleep_mirror_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_W'(`STB_CTRL_OFS) |=>
        reg_rdata_out[`STB_CTRL_SLEEP_BIT] == $past(sleep_req_in))
        else $error("sleep status bit wrong");
    clkreq_off_a: assert property (
        sleep_req_in || (!ctl.enable && st == ST_IDLE) |=> !clock_request_out)
        else $error("clock request high while sleeping or disabled");
    reserved_clk_a: assert property (
        clkev.clock_select[3] && (ctl.mode == `STB_MODE_TIMER) && !ctl.reset &&
        !sleep_req_in && !reg_wr_in |=> $stable(count))
        else $error("reserved clock select counted");
    no_event_a: assert property (
        clkev.edge_sel == `STB_EDGE_ENABLE |-> !ev_hit)
        else $error("edge code 11 produced an event");
    oneshot_go_a: assert property (
        os_start && !reg_wr_in |=>
        st == ST_SHOT && !ctl.enable && count == $past(reload_val))
        else $error("one-shot start wrong");
    reserved_mode_a: assert property (
        ctl.mode == 2'h3 && !ctl.reset && !sleep_req_in && !reg_wr_in |=> $stable(count))
        else $error("reserved mode counted");
    reload_wait_a: assert property (
        running && wr_reload && !step |=> $stable(count))
        else $error("running reload write changed counter");
    count_read_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_W'(`STB_COUNT_OFS) |=>
        reg_rdata_out == {16'h0, $past(count)})
        else $error("count readback wrong");
    reset_bit_a: assert property (
        ctl.reset && !reg_wr_in |=>
        !ctl.reset && !ctl.enable && count == $past(reload_val))
        else $error("reset bit cycle wrong");
    irq_under_a: assert property (
        under |=> irq_out)
        else $error("underflow raised no interrupt");
    wrap_pulse_a: assert property (
        wrap |=> wrap_pulse_out ##1 (wrap_pulse_out == $past(wrap)))
        else $error("wrap pulse wrong");

    timer_wrap_c: cover property (tm_run && wrap);
    event_up_wrap_c: cover property (ev_run && up && wrap);
    oneshot_run_c: cover property (os_start ##[1:300] (os_run && wrap));
endmodule

/* hdl/stb_cfg.svh */
// register map, field codes and reset values of the 16-bit timer
`ifndef STB_CFG_SVH
`define STB_CFG_SVH
`define STB_CTRL_OFS 4'h0
`define STB_CLKEV_OFS 4'h4
`define STB_RELOAD_OFS 4'h8
`define STB_COUNT_OFS 4'hc
`define STB_CTRL_RST 16'h0000
`define STB_CLKEV_RST 16'h0000
`define STB_RELOAD_RST 16'h0fff
`define STB_COUNT_RST 16'hffff
`define STB_CTRL_WMASK 16'h02af
`define STB_CLKEV_WMASK 16'h00ef
`define STB_CTRL_SLEEP_BIT 11
`define STB_CTRL_CLKREQ_BIT 12
`define STB_CNT_MAX 16'hffff
`define STB_CNT_MIN 16'h0000
`define STB_MODE_TIMER 2'h0
`define STB_MODE_EVENT 2'h1
`define STB_MODE_ONESHOT 2'h2
`define STB_EDGE_FALL 2'h0
`define STB_EDGE_RISE 2'h1
`define STB_EDGE_BOTH 2'h2
`define STB_EDGE_ENABLE 2'h3
`define STB_PRESC_ONES 7'h7f
`endif

/* hdl/stb_pkg.sv */
// types shared by the 16-bit timer
package stb_pkg;
    typedef struct packed {
        logic [2:0] rsv_hi;
        logic clk_req;
        logic sleep;
        logic rsv10;
        logic power_down;
        logic rsv8;
        logic reload_on_wrap;
        logic rsv6;
        logic count_direction;
        logic rsv4;
        logic [1:0] mode;
        logic reset;
        logic enable;
    } stb_ctrl_t;
    typedef struct packed {
        logic [7:0] rsv_hi;
        logic event_sel;
        logic [1:0] edge_sel;
        logic rsv4;
        logic [3:0] clock_select;
    } stb_clkev_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SHOT} stb_state_t;
endpackage

/* test/test_sixteen_bit_timer_regs.sv */
// self-checking testbench for the 16-bit timer register block
`timescale 1ns/1ps
`include "stb_cfg.svh"
module test_sixteen_bit_timer_regs;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out;
    logic sleep_req_in = 1'b0;
    logic event_src_in = 1'b0;
    logic clock_request_out;
    logic wrap_pulse_out;
    logic irq_out;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rv;
    int n;
    logic [15:0] ev_cfg [6] = '{16'h0000, 16'h0020, 16'h0040, 16'h0060, 16'h00a0, 16'h0020};
    logic [15:0] ev_ctl [6] = '{16'h0025, 16'h0025, 16'h0025, 16'h0025, 16'h0025, 16'h0005};
    logic [15:0] ev_exp [6] = '{16'h0103, 16'h0103, 16'h0106, 16'h0100, 16'h0100, 16'h00fd};

    always #20 clk_in = ~clk_in;

    stb_timer DUT (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out),
        .sleep_req_in(sleep_req_in),
        .event_src_in(event_src_in),
        .clock_request_out(clock_request_out),
        .wrap_pulse_out(wrap_pulse_out),
        .irq_out(irq_out)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = {16'h0000, d};
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask

    // read data is registered at the read edge, so it is settled at the next falling edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, {16'h0000, exp});
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clk_in);
    endtask

    // bounded wait; returns 1500 when no wrap pulse appeared
    task automatic wait_wrap(output int cyc);
        cyc = 0;
        do begin
            @(negedge clk_in);
            cyc++;
        end while (wrap_pulse_out !== 1'b1 && cyc < 1500);
    endtask

    task automatic pulse_ev(input int k);
        repeat (k) begin
            @(negedge clk_in);
            event_src_in = 1'b1;
            idle(2);
            event_src_in = 1'b0;
            idle(2);
        end
    endtask

    task automatic t_reset;
        rd_chk(`STB_CTRL_OFS, `STB_CTRL_RST);
        rd_chk(`STB_CLKEV_OFS, `STB_CLKEV_RST);
        rd_chk(`STB_RELOAD_OFS, `STB_RELOAD_RST);
        rd_chk(`STB_COUNT_OFS, `STB_COUNT_RST);
        rd_chk(4'h2, 16'h0000);
        wr(`STB_CLKEV_OFS, 16'hffff);
        rd_chk(`STB_CLKEV_OFS, `STB_CLKEV_WMASK);
        wr(`STB_CLKEV_OFS, 16'h0000);
    endtask

    // slow prescaler keeps the count still long enough to read it right after the wrap
    task automatic t_wrap(input logic rl);
        wr(`STB_CLKEV_OFS, 16'h0007);
        wr(`STB_RELOAD_OFS, 16'h0001);
        wr(`STB_CTRL_OFS, rl ? 16'h0081 : 16'h0001);
        wait_wrap(n);
        check(irq_out, 1'b1);
        rd_chk(`STB_COUNT_OFS, rl ? 16'h0001 : 16'hffff);
        wr(`STB_CTRL_OFS, 16'h0000);
    endtask

    task automatic t_clksel;
        wr(`STB_RELOAD_OFS, 16'h0003);
        for (int s = 0; s < 4; s++) begin
            wr(`STB_CLKEV_OFS, 16'(s));
            wr(`STB_CTRL_OFS, 16'h0081);
            wait_wrap(n);
            wait_wrap(n);
            check(n, 32'(4 << s));
            wr(`STB_CTRL_OFS, 16'h0000);
        end
        wr(`STB_CLKEV_OFS, 16'h0008);
        wr(`STB_CTRL_OFS, 16'h0081);
        wait_wrap(n);
        check(n, 32'd1500);
        // reserved mode code must not count even at the fastest clock select
        wr(`STB_CLKEV_OFS, 16'h0000);
        wr(`STB_CTRL_OFS, 16'h000d);
        rd(`STB_COUNT_OFS, rv);
        idle(5);
        rd_chk(`STB_COUNT_OFS, rv[15:0]);
        wr(`STB_CTRL_OFS, 16'h0000);
    endtask

    task automatic t_event;
        for (int i = 0; i < 6; i++) begin
            wr(`STB_CTRL_OFS, 16'h0000);
            wr(`STB_RELOAD_OFS, 16'h0100);
            wr(`STB_CLKEV_OFS, ev_cfg[i]);
            wr(`STB_CTRL_OFS, ev_ctl[i]);
            pulse_ev(3);
            rd_chk(`STB_COUNT_OFS, ev_exp[i]);
        end
        wr(`STB_CTRL_OFS, 16'h0000);
        wr(`STB_RELOAD_OFS, 16'hfffe);
        wr(`STB_CTRL_OFS, 16'h0025);
        pulse_ev(2);
        rd_chk(`STB_COUNT_OFS, 16'h0000);
        wr(`STB_CTRL_OFS, 16'h0000);
    endtask

    task automatic t_sleep;
        wr(`STB_CLKEV_OFS, 16'h0007);
        wr(`STB_RELOAD_OFS, 16'h0020);
        wr(`STB_CTRL_OFS, 16'h0081);
        idle(3);
        check(clock_request_out, 1'b1);
        sleep_req_in = 1'b1;
        idle(3);
        check(clock_request_out, 1'b0);
        rd_chk(`STB_CTRL_OFS, 16'h0881);
        rd_chk(`STB_COUNT_OFS, 16'h0020);
        sleep_req_in = 1'b0;
        idle(3);
        check(clock_request_out, 1'b1);
        rd_chk(`STB_CTRL_OFS, 16'h1081);
        wr(`STB_CLKEV_OFS, 16'h0000);
        wr(`STB_CTRL_OFS, 16'h0281);
        idle(3);
        check(clock_request_out, 1'b0);
        rd(`STB_COUNT_OFS, rv);
        idle(5);
        rd_chk(`STB_COUNT_OFS, rv[15:0]);
        wr(`STB_CTRL_OFS, 16'h0083);
        idle(3);
        rd_chk(`STB_CTRL_OFS, 16'h0080);
        rd_chk(`STB_COUNT_OFS, 16'h0020);
        check(clock_request_out, 1'b0);
        wr(`STB_CLKEV_OFS, 16'h0005);
        wr(`STB_CTRL_OFS, 16'h0081);
        wr(`STB_RELOAD_OFS, 16'h0005);
        rd(`STB_COUNT_OFS, rv);
        check(32'(rv[15:0] > 16'h0005), 32'h1);
        wait_wrap(n);
        rd_chk(`STB_COUNT_OFS, 16'h0005);
        wr(`STB_CTRL_OFS, 16'h0000);
    endtask

    task automatic t_oneshot;
        wr(`STB_CLKEV_OFS, 16'h0060);
        wr(`STB_RELOAD_OFS, 16'h0002);
        wr(`STB_CTRL_OFS, 16'h0089);
        wait_wrap(n);
        check(irq_out, 1'b1);
        idle(3);
        rd_chk(`STB_COUNT_OFS, 16'h0000);
        rd_chk(`STB_CTRL_OFS, 16'h0088);
        wr(`STB_CTRL_OFS, 16'h0000);
        wr(`STB_RELOAD_OFS, 16'h0003);
        wr(`STB_CLKEV_OFS, 16'h0020);
        wr(`STB_CTRL_OFS, 16'h0089);
        idle(10);
        rd_chk(`STB_COUNT_OFS, 16'h0003);
        rd_chk(`STB_CTRL_OFS, 16'h1089);
        pulse_ev(1);
        idle(10);
        rd_chk(`STB_COUNT_OFS, 16'h0000);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // the scenarios need well under 20000 cycles
    initial begin
        repeat (40000) @(posedge clk_in);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_reset();
        t_wrap(1'b0);
        t_wrap(1'b1);
        t_clksel();
        t_event();
        t_sleep();
        t_oneshot();
        wrap_up();
    end
endmodule
